// file: design/sup_pkg.sv
package sup_pkg;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [7:0]  SUP_IDX_POWER      = 8'h87;
    localparam logic [7:0]  SUP_IDX_OPTION     = 8'h94;
    localparam logic [7:0]  SUP_IDX_CONTROL    = 8'h98;
    localparam logic [7:0]  SUP_IDX_BUFFER     = 8'h99;
    localparam logic [7:0]  SUP_IDX_BAUD       = 8'hB0;
    localparam logic [11:0] SUP_ADDR_POWER     = {2'h0, SUP_IDX_POWER, 2'h0};
    localparam logic [11:0] SUP_ADDR_OPTION    = {2'h0, SUP_IDX_OPTION, 2'h0};
    localparam logic [11:0] SUP_ADDR_CONTROL   = {2'h0, SUP_IDX_CONTROL, 2'h0};
    localparam logic [11:0] SUP_ADDR_BUFFER    = {2'h0, SUP_IDX_BUFFER, 2'h0};
    localparam logic [11:0] SUP_ADDR_BAUD      = {2'h0, SUP_IDX_BAUD, 2'h0};

    // Field positions.
    localparam int unsigned SUP_PC_DOUBLER     = 7;
    localparam int unsigned SUP_OPT_ONE_WIRE   = 7;
    localparam int unsigned SUP_SC_MODE_HI     = 7;
    localparam int unsigned SUP_SC_MODE_LO     = 6;
    localparam int unsigned SUP_SC_MP_FILTER   = 5;
    localparam int unsigned SUP_SC_RX_ENABLE   = 4;
    localparam int unsigned SUP_SC_TX_NINTH    = 3;
    localparam int unsigned SUP_SC_RX_NINTH    = 2;
    localparam int unsigned SUP_SC_TX_DONE     = 1;
    localparam int unsigned SUP_SC_RX_DONE     = 0;
    localparam int unsigned SUP_BC_SOURCE      = 31;
    localparam logic [7:0]  SUP_PC_RW_MASK     = 8'h8F;

    // Values after reset.
    localparam logic [7:0]  SUP_POWER_RST      = 8'h00;
    localparam logic [7:0]  SUP_OPTION_RST     = 8'h00;
    localparam logic [7:0]  SUP_CONTROL_RST    = 8'h00;
    localparam logic [7:0]  SUP_BUFFER_RST     = 8'h00;
    localparam logic [31:0] SUP_BAUD_RST       = 32'h0000_0000;

    // Mode select codes.
    localparam logic [1:0]  SUP_MODE_SHIFT     = 2'h0;
    localparam logic [1:0]  SUP_MODE_VAR8      = 2'h1;
    localparam logic [1:0]  SUP_MODE_FIXED9    = 2'h2;
    localparam logic [1:0]  SUP_MODE_VAR9      = 2'h3;

    // Cycle counts. The oversampling tick runs at sixteen times the bit rate.
    localparam int unsigned SUP_RATE_W         = 18;
    localparam logic [3:0]  SUP_OVS_LAST       = 4'hF;
    localparam logic [3:0]  SUP_OVS_MID        = 4'h7;
    localparam logic [17:0] SUP_FIXED_PERIOD   = 18'h00004;
    localparam logic [17:0] SUP_FIXED_PER_DBL  = 18'h00002;
    localparam logic [8:0]  SUP_T1_SPAN        = 9'h100;
    localparam logic [17:0] SUP_T2_SPAN2       = 18'h20000;
    localparam logic [3:0]  SUP_LAST_8BIT      = 4'h9;
    localparam logic [3:0]  SUP_LAST_9BIT      = 4'hA;
    localparam logic [3:0]  SUP_LAST_DATA      = 4'h8;
    localparam logic [2:0]  SUP_SHIFT_LAST     = 3'h7;

    typedef enum logic [1:0] {SUP_SR_IDLE, SUP_SR_TX, SUP_SR_RX} sup_shift_state_t;
    typedef enum logic {SUP_AS_IDLE, SUP_AS_BITS} sup_async_state_t;

endpackage

// file: design/sup_rate_div.sv
`timescale 1ns/1ps
`default_nettype none

// Free running divider; a period change takes effect at the next wrap at the latest.
module sup_rate_div #(
    parameter int unsigned WIDTH = 18
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Rate
    input  wire logic [WIDTH-1:0] period,
    output logic                  tick
);

    logic [WIDTH-1:0] count_reg;
    logic             wrap;

    assign wrap = (count_reg >= (period - WIDTH'(1)));
    assign tick = wrap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (wrap) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + WIDTH'(1);
        end
    end

endmodule

`default_nettype wire

// file: design/sup_serial_port.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE_01: Mode 00 is an 8-bit shift register at half the system clock.
// RULE_02: Mode 01 is an 8-bit asynchronous UART at a timer derived rate.
// RULE_03: Mode 10 is a 9-bit asynchronous UART at clock over 32 or 64.
// RULE_04: Mode 11 is a 9-bit asynchronous UART at a timer derived rate.
// RULE_05: In 9-bit modes with filter set, ninth bit zero raises no receive flag.
// RULE_06: In mode 01 with filter set, receive flag needs a valid stop bit.
// RULE_07: Software keeps the filter bit zero in shift register mode.
// RULE_08: Reception happens only while the receive enable bit is one; mode 00 finishes a started reception even if the bit is cleared.
// RULE_09: In 9-bit modes the transmit ninth bit control is sent as bit nine.
// RULE_10: Received ninth bit is stored; in mode 01 with filter clear, the stop bit.
// RULE_11: Transmit flag sets after bit eight in mode 00, else at stop start; sticky.
// RULE_12: Receive flag sets after bit eight in mode 00, else at stop sample; sticky.
// RULE_13: Buffer writes feed transmit, reads return receive; separate storage.
// RULE_14: One-wire select puts transmit and receive on one shared pin.
// RULE_15: Doubler doubles the rate in timer 1 variable modes and fixed mode.
// RULE_16: Timer 1 rate is (doubler+1) clock over 64 times (256 minus reload).
// RULE_17: Timer 2 rate is clock over 32 times (65536 minus 16-bit reload).
// RULE_18: Fixed 9-bit rate is (doubler+1) times clock over 64.
// RULE_19: Frames are start low, data LSB first, stop high; idle line high.
// RULE_20: Control, option, power and data bits are zero after reset.
module sup_serial_port
    import sup_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Transmit pin (serial out, shift clock in mode 00)
    output logic             txd_out,
    output logic             txd_oe,
    // Receive pin (data in mode 00, shared line in one-wire mode)
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe
);

    logic [7:0]       power_control_reg;
    logic [7:0]       misc_option_reg;
    logic [7:0]       serial_control_reg;
    logic [7:0]       rx_buffer_reg;
    logic [31:0]      baud_config_reg;
    logic [31:0]      prdata_reg;
    logic             pslverr_reg;
    logic             rx_meta_reg, rx_sync_reg, rx_prev_reg;
    sup_shift_state_t sr_state_reg;
    logic             sr_phase_reg;
    logic [2:0]       sr_count_reg;
    logic [7:0]       sr_shift_reg;
    sup_async_state_t tx_state_reg, rx_state_reg;
    logic [3:0]       tx_tick_reg, tx_index_reg, tx_last_reg;
    logic [10:0]      tx_shift_reg;
    logic [3:0]       rx_tick_reg, rx_index_reg;
    logic [7:0]       rx_shift_reg;
    logic             rx_ninth_reg;

    logic [1:0]       mode;
    logic             shift_mode, nine_bit, doubler, one_wire;
    logic             mp_filter, rx_enable, tb8, ti, ri;
    logic             setup, access_wr, mapped;
    logic             wr_power, wr_option, wr_control, wr_buffer, wr_baud;
    logic [31:0]      rdata_next;
    logic [8:0]       t1_span;
    logic [17:0]      rate_period;
    logic             ovs_tick;
    logic             tx_load, tx_bit_end, tx_enter_stop, tx_line;
    logic             sr_done, rx_start_edge, rx_sample, rx_stop_evt;
    logic             rx_last_bit, rx_accept, ti_set, ri_set;
    logic [7:0]       serial_control_next;

    assign mode       = serial_control_reg[SUP_SC_MODE_HI:SUP_SC_MODE_LO];
    assign shift_mode = (mode == SUP_MODE_SHIFT);
    assign nine_bit   = mode[1];
    assign doubler    = power_control_reg[SUP_PC_DOUBLER];
    assign one_wire   = misc_option_reg[SUP_OPT_ONE_WIRE];
    assign mp_filter  = serial_control_reg[SUP_SC_MP_FILTER];
    assign rx_enable  = serial_control_reg[SUP_SC_RX_ENABLE];
    assign tb8        = serial_control_reg[SUP_SC_TX_NINTH];
    assign ti         = serial_control_reg[SUP_SC_TX_DONE];
    assign ri         = serial_control_reg[SUP_SC_RX_DONE];

    // Zero wait states: read data is captured in the setup cycle.
    assign pready    = 1'b1;
    assign prdata    = prdata_reg;
    assign pslverr   = pslverr_reg;
    assign setup     = psel && !penable;
    assign access_wr = psel && penable && pwrite && !pslverr_reg;
    assign wr_power   = access_wr && (paddr == SUP_ADDR_POWER) && pstrb[0];
    assign wr_option  = access_wr && (paddr == SUP_ADDR_OPTION) && pstrb[0];
    assign wr_control = access_wr && (paddr == SUP_ADDR_CONTROL) && pstrb[0];
    assign wr_buffer  = access_wr && (paddr == SUP_ADDR_BUFFER) && pstrb[0];
    assign wr_baud    = access_wr && (paddr == SUP_ADDR_BAUD);

    always_comb begin
        mapped     = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr)
            SUP_ADDR_POWER:   rdata_next[7:0] = power_control_reg;
            SUP_ADDR_OPTION:  rdata_next[7:0] = misc_option_reg;
            SUP_ADDR_CONTROL: rdata_next[7:0] = serial_control_reg;
            SUP_ADDR_BUFFER:  rdata_next[7:0] = rx_buffer_reg; // RULE_13
            SUP_ADDR_BAUD:    rdata_next      = baud_config_reg;
            default:          mapped          = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr_reg <= !mapped;
        end
    end

    // Register writes; unwritten power bits 6..4 stay zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_control_reg <= SUP_POWER_RST; // RULE_20
            misc_option_reg   <= SUP_OPTION_RST;
            baud_config_reg   <= SUP_BAUD_RST;
        end else begin
            if (wr_power) begin
                power_control_reg <= pwdata[7:0] & SUP_PC_RW_MASK;
            end
            if (wr_option) begin
                misc_option_reg <= pwdata[7:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (wr_baud && pstrb[i]) begin
                    baud_config_reg[i*8 +: 8] <= pwdata[i*8 +: 8];
                end
            end
        end
    end

    // Rate source: fixed mode, or the timer 1 / timer 2 reload values.
    always_comb begin
        t1_span = SUP_T1_SPAN - {1'b0, baud_config_reg[7:0]};
        if (mode == SUP_MODE_FIXED9) begin
            rate_period = doubler ? SUP_FIXED_PER_DBL : SUP_FIXED_PERIOD; // RULE_03 RULE_18 RULE_15
        end else if (baud_config_reg[SUP_BC_SOURCE]) begin
            rate_period = SUP_T2_SPAN2 - {1'b0, baud_config_reg[23:8], 1'b0}; // RULE_17
        end else if (doubler) begin
            rate_period = {8'h00, t1_span, 1'b0}; // RULE_16 RULE_15
        end else begin
            rate_period = {7'h00, t1_span, 2'h0}; // RULE_16
        end
    end

    sup_rate_div #(
        .WIDTH (SUP_RATE_W)
    ) u_rate (
        .pclk    (pclk),
        .presetn (presetn),
        .period  (rate_period),
        .tick    (ovs_tick)
    );

    // Pin synchroniser; the edge detector compares the second and third stages.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_meta_reg <= rxd_in;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    // Shift register mode: each bit is one low and one high clock cycle.
    assign sr_done = (sr_state_reg != SUP_SR_IDLE) && sr_phase_reg
                     && (sr_count_reg == SUP_SHIFT_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_state_reg <= SUP_SR_IDLE;
            sr_phase_reg <= 1'b0;
            sr_count_reg <= 3'h0;
            sr_shift_reg <= 8'h00;
        end else if (!shift_mode) begin
            sr_state_reg <= SUP_SR_IDLE;
        end else begin
            case (sr_state_reg)
                SUP_SR_IDLE: begin
                    sr_phase_reg <= 1'b0;
                    sr_count_reg <= 3'h0;
                    if (wr_buffer) begin
                        sr_state_reg <= SUP_SR_TX;
                        sr_shift_reg <= pwdata[7:0];
                    end else if (rx_enable && !ri) begin
                        sr_state_reg <= SUP_SR_RX; // RULE_08
                    end
                end
                SUP_SR_TX, SUP_SR_RX: begin
                    sr_phase_reg <= !sr_phase_reg; // RULE_01
                    if (sr_phase_reg) begin
                        sr_count_reg <= sr_count_reg + 3'h1;
                        sr_shift_reg <= {rx_sync_reg, sr_shift_reg[7:1]};
                        if (sr_done) begin
                            sr_state_reg <= SUP_SR_IDLE;
                        end
                    end
                end
                default: sr_state_reg <= SUP_SR_IDLE;
            endcase
        end
    end

    // Asynchronous transmitter; a buffer write while busy is ignored.
    assign tx_load       = wr_buffer && !shift_mode && (tx_state_reg == SUP_AS_IDLE);
    assign tx_bit_end    = (tx_state_reg == SUP_AS_BITS) && ovs_tick
                           && (tx_tick_reg == SUP_OVS_LAST);
    assign tx_enter_stop = tx_bit_end && ((tx_index_reg + 4'h1) == tx_last_reg);
    assign tx_line       = (tx_state_reg == SUP_AS_BITS) ? tx_shift_reg[0] : 1'b1; // RULE_19

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= SUP_AS_IDLE;
            tx_tick_reg  <= 4'h0;
            tx_index_reg <= 4'h0;
            tx_last_reg  <= SUP_LAST_8BIT;
            tx_shift_reg <= 11'h7FF;
        end else begin
            case (tx_state_reg)
                SUP_AS_IDLE: begin
                    if (tx_load) begin
                        tx_state_reg <= SUP_AS_BITS;
                        tx_tick_reg  <= 4'h0;
                        tx_index_reg <= 4'h0;
                        tx_last_reg  <= nine_bit ? SUP_LAST_9BIT : SUP_LAST_8BIT; // RULE_02 RULE_04
                        tx_shift_reg <= {1'b1, nine_bit ? tb8 : 1'b1, pwdata[7:0], 1'b0}; // RULE_09 RULE_19
                    end
                end
                SUP_AS_BITS: begin
                    if (ovs_tick) begin
                        tx_tick_reg <= tx_tick_reg + 4'h1;
                    end
                    if (tx_bit_end) begin
                        if (tx_index_reg == tx_last_reg) begin
                            tx_state_reg <= SUP_AS_IDLE;
                        end else begin
                            tx_index_reg <= tx_index_reg + 4'h1;
                            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                        end
                    end
                end
                default: tx_state_reg <= SUP_AS_IDLE;
            endcase
        end
    end

    // Asynchronous receiver, sampling at the middle of each bit.
    // In one-wire mode the receiver ignores the line while we transmit on it.
    assign rx_start_edge = rx_prev_reg && !rx_sync_reg
                           && !(one_wire && (tx_state_reg == SUP_AS_BITS)); // RULE_14
    assign rx_sample     = (rx_state_reg == SUP_AS_BITS) && ovs_tick
                           && (rx_tick_reg == SUP_OVS_MID);
    assign rx_last_bit   = nine_bit ? (rx_index_reg == SUP_LAST_9BIT)
                                    : (rx_index_reg == SUP_LAST_8BIT);
    assign rx_stop_evt   = rx_sample && rx_last_bit;

    always_comb begin
        if (nine_bit) begin
            rx_accept = rx_stop_evt && (!mp_filter || rx_ninth_reg); // RULE_05
        end else begin
            rx_accept = rx_stop_evt && (!mp_filter || rx_sync_reg); // RULE_06
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_reg <= SUP_AS_IDLE;
            rx_tick_reg  <= 4'h0;
            rx_index_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            rx_ninth_reg <= 1'b0;
        end else if (!rx_enable || shift_mode) begin
            rx_state_reg <= SUP_AS_IDLE; // RULE_08
        end else begin
            case (rx_state_reg)
                SUP_AS_IDLE: begin
                    rx_tick_reg  <= 4'h0;
                    rx_index_reg <= 4'h0;
                    if (rx_start_edge) begin
                        rx_state_reg <= SUP_AS_BITS;
                    end
                end
                SUP_AS_BITS: begin
                    if (ovs_tick) begin
                        rx_tick_reg <= rx_tick_reg + 4'h1;
                    end
                    if (rx_sample) begin
                        rx_index_reg <= rx_index_reg + 4'h1;
                        // A start bit that is high again at mid-bit was a glitch.
                        if ((rx_index_reg == 4'h0 && rx_sync_reg) || rx_last_bit) begin
                            rx_state_reg <= SUP_AS_IDLE;
                        end
                        if (rx_index_reg != 4'h0 && rx_index_reg <= SUP_LAST_DATA) begin
                            rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]}; // RULE_19
                        end
                        if (rx_index_reg == SUP_LAST_8BIT) begin
                            rx_ninth_reg <= rx_sync_reg;
                        end
                    end
                end
                default: rx_state_reg <= SUP_AS_IDLE;
            endcase
        end
    end

    // Flags: a hardware set wins over a software write in the same cycle.
    assign ti_set = tx_enter_stop || (sr_done && sr_state_reg == SUP_SR_TX); // RULE_11
    assign ri_set = rx_accept || (sr_done && sr_state_reg == SUP_SR_RX); // RULE_12

    always_comb begin
        serial_control_next = wr_control ? pwdata[7:0] : serial_control_reg;
        if (rx_accept) begin
            serial_control_next[SUP_SC_RX_NINTH] = nine_bit ? rx_ninth_reg : rx_sync_reg; // RULE_10
        end
        if (ti_set) begin
            serial_control_next[SUP_SC_TX_DONE] = 1'b1;
        end
        if (ri_set) begin
            serial_control_next[SUP_SC_RX_DONE] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_reg <= SUP_CONTROL_RST; // RULE_20
            rx_buffer_reg      <= SUP_BUFFER_RST;
        end else begin
            serial_control_reg <= serial_control_next;
            if (rx_accept) begin
                rx_buffer_reg <= rx_shift_reg; // RULE_13
            end else if (sr_done && sr_state_reg == SUP_SR_RX) begin
                rx_buffer_reg <= {rx_sync_reg, sr_shift_reg[7:1]};
            end
        end
    end

    // Pins. The shift clock idles high; one-wire mode moves the line to the receive pin.
    always_comb begin
        if (shift_mode) begin
            txd_out = (sr_state_reg == SUP_SR_IDLE) ? 1'b1 : sr_phase_reg; // RULE_01
            txd_oe  = 1'b1;
            rxd_out = sr_shift_reg[0];
            rxd_oe  = (sr_state_reg == SUP_SR_TX);
        end else begin
            txd_out = tx_line;
            txd_oe  = !one_wire; // RULE_14
            rxd_out = tx_line;
            rxd_oe  = one_wire && (tx_state_reg == SUP_AS_BITS); // RULE_14
        end
    end

    shift_clock_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        (shift_mode && sr_state_reg != SUP_SR_IDLE && !sr_phase_reg) |=> txd_out)
        else $error("shift clock not high in second half of bit");

    ninth_filter_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        (rx_stop_evt && nine_bit && mp_filter && !rx_ninth_reg && !ri && !wr_control)
        |=> !ri)
        else $error("receive flag raised for filtered address frame");

    stop_filter_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        (rx_stop_evt && mode == SUP_MODE_VAR8 && mp_filter && !rx_sync_reg && !ri
         && !wr_control) |=> !ri)
        else $error("receive flag raised without valid stop bit");

    rx_disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        !rx_enable |=> (rx_state_reg == SUP_AS_IDLE) && !rx_accept)
        else $error("receiver active while disabled");

    ninth_tx_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
        (tx_load && nine_bit) |=> (tx_shift_reg[9] == $past(tb8)) && (tx_last_reg == SUP_LAST_9BIT))
        else $error("ninth transmit bit does not follow control");

    tx_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
        tx_enter_stop |=> ti && tx_line)
        else $error("transmit flag missing at stop bit start");

    rx_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
        rx_accept |=> ri && (rx_buffer_reg == $past(rx_shift_reg)))
        else $error("receive flag or data missing after accepted frame");

    buffer_split_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        (wr_buffer && !rx_accept && !sr_done) |=> $stable(rx_buffer_reg))
        else $error("buffer write disturbed receive data");

    one_wire_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
        (one_wire && !shift_mode) |-> !txd_oe && (rxd_oe == (tx_state_reg == SUP_AS_BITS)))
        else $error("one-wire pin drive wrong");

    fixed_rate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        (ovs_tick && mode == SUP_MODE_FIXED9 && !doubler && !wr_control && !wr_power)
        |=> !ovs_tick [*3] ##1 ovs_tick)
        else $error("fixed mode oversampling period wrong");

endmodule

`default_nettype wire

// file: sim/sup_remote.sv
`timescale 1ns/1ps
`default_nettype none
// The remote station holds its line high between frames, as an idle line would rest.
module sup_remote (
    // Serial lines
    input  wire logic line_in,
    output logic      line_out,
    // Clocks
    input  wire logic pclk,
    input  wire logic shift_clk
);
    localparam int BIT_CYC = 64;
    logic [9:0] got;
    logic [7:0] sh;
    initial line_out = 1'b1;
    // In shift register mode a data bit is taken at each rising edge of the shift clock.
    always @(posedge shift_clk) sh <= {line_in, sh[7:1]};
    task automatic send(input logic [8:0] v, input int n);
        line_out <= 1'b0;
        repeat (BIT_CYC) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            line_out <= v[i];
            repeat (BIT_CYC) @(posedge pclk);
        end
        line_out <= 1'b1;
        repeat (BIT_CYC) @(posedge pclk);
    endtask
    // Sampling at mid-bit tolerates the short first bit of a free-running tick.
    task automatic listen(input int n);
        got = 10'h000;
        while (line_in !== 1'b0) @(posedge pclk);
        repeat (BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i <= n; i++) begin
            repeat (BIT_CYC) @(posedge pclk);
            got[i] = line_in;
        end
    endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import sup_pkg::*;
;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, se, txd_out, rxd_in, txd_oe, rxd_out, rxd_oe;
    int          err_count = 0;
    int          tests_run = 0;
    logic [8:0]  frm [3] = '{9'h055, 9'h13C, 9'h13C};
    logic [7:0]  ctl [3] = '{8'hB0, 8'h80, 8'h90};
    logic        done [3] = '{1'b0, 1'b0, 1'b1};
    logic [11:0] rst_a [3] = '{SUP_ADDR_POWER, SUP_ADDR_OPTION, SUP_ADDR_CONTROL};
    always #10 pclk = ~pclk;
    sup_serial_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .txd_out(txd_out), .txd_oe(txd_oe),
        .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe));
    // The remote hears the shared receive pin whenever the block drives it.
    sup_remote i_rem (.line_in(rxd_oe ? rxd_out : txd_out), .line_out(rxd_in), .pclk(pclk),
        .shift_clk(txd_out));
    // An idle edge before each setup keeps two transfers from driving psel in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, rst_a[k], 32'h0000_0000);
            chk("reset value", 32'h0000_0000, rd);
        end
        apb(1'b0, 12'h3F0, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, se});
        apb(1'b1, SUP_ADDR_BUFFER, 32'h0000_005A);
        repeat (20) @(posedge pclk);
        chk("shift data", 32'h0000_005A, {24'h0, i_rem.sh});
        apb(1'b0, SUP_ADDR_CONTROL, 32'h0000_0000);
        chk("shift done", 32'h0000_0002, rd);
        apb(1'b1, SUP_ADDR_CONTROL, 32'h0000_0088);
        fork
            i_rem.listen(9);
            apb(1'b1, SUP_ADDR_BUFFER, 32'h0000_00A5);
        join
        chk("tx frame", 32'h0000_03A5, {22'h0, i_rem.got});
        apb(1'b0, SUP_ADDR_CONTROL, 32'h0000_0000);
        chk("tx done", 32'h0000_008A, rd);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, SUP_ADDR_CONTROL, {24'h0, ctl[k]});
            i_rem.send(frm[k], 9);
            apb(1'b0, SUP_ADDR_CONTROL, 32'h0000_0000);
            chk("rx done", {31'h0, done[k]}, {31'h0, rd[0]});
        end
        chk("rx ninth", 32'h0000_0001, {31'h0, rd[2]});
        apb(1'b0, SUP_ADDR_BUFFER, 32'h0000_0000);
        chk("rx data", 32'h0000_003C, rd);
        // Reload 0xFF keeps the tick period of the fixed mode across the mode change.
        apb(1'b1, SUP_ADDR_BAUD, 32'h0000_00FF);
        apb(1'b1, SUP_ADDR_CONTROL, 32'h0000_0070);
        i_rem.send(9'h0C3, 9);
        apb(1'b0, SUP_ADDR_CONTROL, 32'h0000_0000);
        chk("stop filter", 32'h0000_0070, rd);
        apb(1'b1, SUP_ADDR_BAUD, 32'h0000_00FE);
        apb(1'b1, SUP_ADDR_POWER, 32'h0000_0080);
        i_rem.send(9'h1C3, 8);
        apb(1'b0, SUP_ADDR_CONTROL, 32'h0000_0000);
        chk("var8 flags", 32'h0000_0075, rd);
        apb(1'b0, SUP_ADDR_BUFFER, 32'h0000_0000);
        chk("var8 data", 32'h0000_00C3, rd);
        apb(1'b1, SUP_ADDR_BAUD, 32'h80FF_FE00);
        apb(1'b1, SUP_ADDR_CONTROL, 32'h0000_00C0);
        apb(1'b1, SUP_ADDR_OPTION, 32'h0000_0080);
        fork
            i_rem.listen(9);
            apb(1'b1, SUP_ADDR_BUFFER, 32'h0000_0096);
            begin
                repeat (8) @(posedge pclk);
                chk("one wire drive", 32'h0000_0001, {30'h0, txd_oe, rxd_oe});
            end
        join
        chk("var9 frame", 32'h0000_0296, {22'h0, i_rem.got});
        close_out();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
